// [sccr_pkg.sv]
// Purpose: Constants for the scrub channel configuration register bank
// Assumes: 32-bit register port, byte addresses, aligned words
// Notes:   Channels 5 to 7 plus the channel 4 end address
package sccr_pkg;
  localparam int unsigned ADDR_W          = 12;
  localparam logic [11:0] OFF_CH4_END     = 12'h1b8;
  localparam logic [11:0] OFF_CH5_CTRL    = 12'h1c0;
  localparam logic [11:0] OFF_CH5_START   = 12'h1c4;
  localparam logic [11:0] OFF_CH5_END     = 12'h1c8;
  localparam logic [11:0] OFF_CH6_CTRL    = 12'h1d0;
  localparam logic [11:0] OFF_CH6_START   = 12'h1d4;
  localparam logic [11:0] OFF_CH6_END     = 12'h1d8;
  localparam logic [11:0] OFF_CH7_CTRL    = 12'h1e0;
  localparam logic [11:0] OFF_CH7_START   = 12'h1e4;
  localparam logic [11:0] OFF_IRQ_STATUS  = 12'h200;
  localparam logic [11:0] OFF_IRQ_MASK    = 12'h204;
  localparam logic [31:0] CTRL_RESET      = 32'h1f000000;
  localparam logic [31:0] ADDR_RESET      = 32'h00000000;
  localparam logic [31:0] CTRL_WMASK      = 32'h1f0f3e4b;
  localparam int unsigned LIMIT_LSB       = 24;
  localparam int unsigned LIMIT_W         = 5;
  localparam int unsigned ESC_LSB         = 16;
  localparam int unsigned ESC_W           = 4;
  localparam int unsigned PAUSE_BIT       = 13;
  localparam int unsigned QOS_LSB         = 9;
  localparam int unsigned QOS_W           = 4;
  localparam int unsigned DONE_EN_BIT     = 6;
  localparam int unsigned FMT_BIT         = 3;
  localparam int unsigned TRIG_LSB        = 0;
  localparam int unsigned TRIG_W          = 2;
  localparam int unsigned RANK_LSB        = 22;
  localparam int unsigned RANK_W          = 3;
  localparam int unsigned BANK_LSB        = 18;
  localparam int unsigned BANK_W          = 4;
  localparam int unsigned ROW_LSB         = 0;
  localparam int unsigned ROW_W           = 18;
  localparam int unsigned NCH             = 3;
endpackage

// [sccr_chan.sv]
// Purpose: One scrub channel: control, start and end registers and decode
// Assumes: Write strobe already qualified by address in the parent
// Notes:   Reserved control bits never store
module sccr_chan
  import sccr_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire logic                         ctrl_we,
  input  wire logic                         start_we,
  input  wire logic                         end_we,
  input  wire logic [31:0]                  wdata,
  output logic      [31:0]                  ctrl_reg,
  output logic      [31:0]                  start_reg,
  output logic      [31:0]                  end_reg,
  output logic      [sccr_pkg::LIMIT_W-1:0] max_inflight_requests,
  output logic      [sccr_pkg::ESC_W-1:0]   priority_raise_periods,
  output logic                              escalation_enable,
  output logic                              pause_at_row_boundary,
  output logic      [sccr_pkg::QOS_W-1:0]   service_class,
  output logic                              done_event_enable,
  output logic                              address_format_select,
  output logic      [sccr_pkg::TRIG_W-1:0]  start_source,
  output logic      [sccr_pkg::RANK_W-1:0]  start_rank,
  output logic      [sccr_pkg::BANK_W-1:0]  start_bank,
  output logic      [sccr_pkg::ROW_W-1:0]   start_row,
  output logic      [sccr_pkg::RANK_W-1:0]  end_rank,
  output logic      [sccr_pkg::BANK_W-1:0]  end_bank,
  output logic      [sccr_pkg::ROW_W-1:0]   end_row
);
  import sccr_pkg::*;

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_we) begin
      ctrl_reg <= wdata & CTRL_WMASK;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      start_reg <= ADDR_RESET;
    end else if (start_we) begin
      start_reg <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      end_reg <= ADDR_RESET;
    end else if (end_we) begin
      end_reg <= wdata;
    end
  end

  assign max_inflight_requests  = ctrl_reg[LIMIT_LSB +: LIMIT_W];
  assign priority_raise_periods = ctrl_reg[ESC_LSB +: ESC_W];
  assign escalation_enable      = |ctrl_reg[ESC_LSB +: ESC_W];
  assign pause_at_row_boundary  = ctrl_reg[PAUSE_BIT];
  assign service_class          = ctrl_reg[QOS_LSB +: QOS_W];
  assign done_event_enable      = ctrl_reg[DONE_EN_BIT];
  assign address_format_select  = ctrl_reg[FMT_BIT];
  assign start_source           = ctrl_reg[TRIG_LSB +: TRIG_W];

  assign start_rank = start_reg[RANK_LSB +: RANK_W];
  assign start_bank = start_reg[BANK_LSB +: BANK_W];
  assign start_row  = start_reg[ROW_LSB +: ROW_W];
  assign end_rank   = end_reg[RANK_LSB +: RANK_W];
  assign end_bank   = end_reg[BANK_LSB +: BANK_W];
  assign end_row    = end_reg[ROW_LSB +: ROW_W];
endmodule

// [sccr_regs.sv]
// Purpose: Scrub channel configuration register bank, channels 5 to 7
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   Completion events gated by the enable bit into sticky status
//
// How it works
// - In physical format the address words hold rank 24:22, bank 21:18 and row 17:0.
// - In system format the address words are used whole, as system transactions carry them.
// - Each channel has a 32-bit start address register.
// - Channels 5 and 6 have a 32-bit end address register; channel 7 has none in this bank.
// - Control bits 28:24 cap inflight requests; software keeps it within 8 to 31.
// - Control bits 19:16 count prescaler periods before priority rises, zero disables.
// - Control bit 13 makes the channel pause at a row boundary.
// - Control bits 12:9 are the QoS attached to every scrub operation.
// - Control bit 6 lets a finished sequence raise an event; clear means no event.
// - Control bit 3 selects physical or system address format.
// - Control bits 1:0 select the start trigger.
// - Control resets to 0x1f000000 and address registers to zero.
// - Every register is readable at any time; all but IRQ status are writable, and writing ones to IRQ status clears those bits.
//
// Local design decision: the strobed register port.
module sccr_regs
  import sccr_pkg::*;
(
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [sccr_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [31:0]                reg_rdata,
  input  wire logic [sccr_pkg::NCH-1:0]   seq_done,
  output logic                            irq,
  output logic      [31:0]                ch4_end_address,
  output logic                            ch4_address_format_select,
  output logic      [sccr_pkg::NCH*32-1:0] ch_start_address,
  output logic      [sccr_pkg::NCH*32-1:0] ch_end_address,
  output logic      [sccr_pkg::NCH*5-1:0] ch_max_inflight_requests,
  output logic      [sccr_pkg::NCH*4-1:0] ch_priority_raise_periods,
  output logic      [sccr_pkg::NCH-1:0]   ch_escalation_enable,
  output logic      [sccr_pkg::NCH-1:0]   ch_pause_at_row_boundary,
  output logic      [sccr_pkg::NCH*4-1:0] ch_service_class,
  output logic      [sccr_pkg::NCH-1:0]   ch_address_format_select,
  output logic      [sccr_pkg::NCH*2-1:0] ch_start_source,
  output logic      [sccr_pkg::NCH*3-1:0] ch_start_rank,
  output logic      [sccr_pkg::NCH*4-1:0] ch_start_bank,
  output logic      [sccr_pkg::NCH*18-1:0] ch_start_row,
  output logic      [sccr_pkg::NCH*3-1:0] ch_end_rank,
  output logic      [sccr_pkg::NCH*4-1:0] ch_end_bank,
  output logic      [sccr_pkg::NCH*18-1:0] ch_end_row,
  output logic      [sccr_pkg::NCH-1:0]   ch_done_event
);
  import sccr_pkg::*;

  logic [31:0]     ch4_end_reg;
  logic [31:0]     ctrl_q   [NCH];
  logic [31:0]     start_q  [NCH];
  logic [31:0]     end_q    [NCH];
  logic [NCH-1:0]  done_en;
  logic [NCH-1:0]  ctrl_we;
  logic [NCH-1:0]  start_we;
  logic [NCH-1:0]  end_we;
  logic [NCH-1:0]  irq_status_reg;
  logic [NCH-1:0]  irq_mask_reg;
  logic [NCH-1:0]  irq_status_next;
  logic [31:0]     rdata_next;

  // Ch7 end is not in this bank; its write strobe is tied off
  assign ctrl_we[0]  = reg_wr && (reg_addr == OFF_CH5_CTRL);
  assign ctrl_we[1]  = reg_wr && (reg_addr == OFF_CH6_CTRL);
  assign ctrl_we[2]  = reg_wr && (reg_addr == OFF_CH7_CTRL);
  assign start_we[0] = reg_wr && (reg_addr == OFF_CH5_START);
  assign start_we[1] = reg_wr && (reg_addr == OFF_CH6_START);
  assign start_we[2] = reg_wr && (reg_addr == OFF_CH7_START);
  assign end_we[0]   = reg_wr && (reg_addr == OFF_CH5_END);
  assign end_we[1]   = reg_wr && (reg_addr == OFF_CH6_END);
  assign end_we[2]   = 1'b0;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : gen_ch
      sccr_chan u_chan (
        .clk                    (clk),
        .rst                    (rst),
        .ctrl_we                (ctrl_we[g]),
        .start_we               (start_we[g]),
        .end_we                 (end_we[g]),
        .wdata                  (reg_wdata),
        .ctrl_reg               (ctrl_q[g]),
        .start_reg              (start_q[g]),
        .end_reg                (end_q[g]),
        .max_inflight_requests  (ch_max_inflight_requests[g*5 +: 5]),
        .priority_raise_periods (ch_priority_raise_periods[g*4 +: 4]),
        .escalation_enable      (ch_escalation_enable[g]),
        .pause_at_row_boundary  (ch_pause_at_row_boundary[g]),
        .service_class          (ch_service_class[g*4 +: 4]),
        .done_event_enable      (done_en[g]),
        .address_format_select  (ch_address_format_select[g]),
        .start_source           (ch_start_source[g*2 +: 2]),
        .start_rank             (ch_start_rank[g*3 +: 3]),
        .start_bank             (ch_start_bank[g*4 +: 4]),
        .start_row              (ch_start_row[g*18 +: 18]),
        .end_rank               (ch_end_rank[g*3 +: 3]),
        .end_bank               (ch_end_bank[g*4 +: 4]),
        .end_row                (ch_end_row[g*18 +: 18])
      );
      assign ch_start_address[g*32 +: 32] = start_q[g];
      assign ch_end_address[g*32 +: 32]   = end_q[g];
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      ch4_end_reg <= ADDR_RESET;
    end else if (reg_wr && (reg_addr == OFF_CH4_END)) begin
      ch4_end_reg <= reg_wdata;
    end
  end
  assign ch4_end_address = ch4_end_reg;
  // Ch4 control lives elsewhere; its format bit is not held here
  assign ch4_address_format_select = 1'b0;

  always_ff @(posedge clk) begin
    if (rst) begin
      ch_done_event <= '0;
    end else begin
      ch_done_event <= seq_done & done_en;
    end
  end

  // Set wins over a same-cycle write-one clear
  always_comb begin
    irq_status_next = irq_status_reg;
    if (reg_wr && (reg_addr == OFF_IRQ_STATUS)) begin
      irq_status_next = irq_status_next & ~reg_wdata[NCH-1:0];
    end
    irq_status_next = irq_status_next | (seq_done & done_en);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_reg <= '0;
    end else if (reg_wr && (reg_addr == OFF_IRQ_MASK)) begin
      irq_mask_reg <= reg_wdata[NCH-1:0];
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  always_comb begin
    case (reg_addr)
      OFF_CH4_END:    rdata_next = ch4_end_reg;
      OFF_CH5_CTRL:   rdata_next = ctrl_q[0];
      OFF_CH5_START:  rdata_next = start_q[0];
      OFF_CH5_END:    rdata_next = end_q[0];
      OFF_CH6_CTRL:   rdata_next = ctrl_q[1];
      OFF_CH6_START:  rdata_next = start_q[1];
      OFF_CH6_END:    rdata_next = end_q[1];
      OFF_CH7_CTRL:   rdata_next = ctrl_q[2];
      OFF_CH7_START:  rdata_next = start_q[2];
      OFF_IRQ_STATUS: rdata_next = {29'h0, irq_status_reg};
      OFF_IRQ_MASK:   rdata_next = {29'h0, irq_mask_reg};
      default:        rdata_next = 32'h0;
    endcase
  end

  // Unmapped reads return zero, no error path
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= 32'h0;
    end
  end
endmodule

// [sccr_regs_monitor.sv]
// Purpose: Port checks for the scrub register bank
// Assumes: One clock, synchronous active high reset
// Notes:   Sees only top-level ports
module sccr_regs_monitor
  import sccr_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [2:0]  seq_done,
  input wire logic        irq,
  input wire logic [2:0]  ch_done_event,
  input wire logic [14:0] ch_max_inflight_requests,
  input wire logic [11:0] ch_priority_raise_periods,
  input wire logic [2:0]  ch_escalation_enable,
  input wire logic [11:0] ch_service_class,
  input wire logic [8:0]  ch_start_rank,
  input wire logic [53:0] ch_start_row
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  property p_ctrl_mask;
    reg_wr && reg_addr == OFF_CH5_CTRL ##1 reg_rd && reg_addr == OFF_CH5_CTRL
    |=> reg_rdata == ($past(reg_wdata, 2) & 32'h1f0f3e4b);
  endproperty
  property p_evt_src; ch_done_event != 3'h0 |-> (ch_done_event & ~$past(seq_done)) == 3'h0; endproperty
  property p_irq_cause; $rose(irq) |-> ch_done_event != 3'h0 || $past(reg_wr && reg_addr == OFF_IRQ_MASK); endproperty
  property p_esc;
    reg_wr && reg_addr == OFF_CH5_CTRL |=> ch_priority_raise_periods[3:0] == $past(reg_wdata[19:16])
    && ch_escalation_enable[0] == ($past(reg_wdata[19:16]) != 4'h0);
  endproperty
  property p_limit_qos;
    reg_wr && reg_addr == OFF_CH6_CTRL |=> ch_max_inflight_requests[9:5] == $past(reg_wdata[28:24])
    && ch_service_class[7:4] == $past(reg_wdata[12:9]);
  endproperty
  property p_rank_row;
    reg_wr && reg_addr == OFF_CH7_START |=> ch_start_rank[8:6] == $past(reg_wdata[24:22])
    && ch_start_row[53:36] == $past(reg_wdata[17:0]);
  endproperty
  // Fields move only on a write
  property p_hold; !reg_wr |=> $stable(ch_max_inflight_requests) && $stable(ch_service_class); endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_ctrl_mask: assert property (p_ctrl_mask) else $error("control readback bad");
  a_evt_src: assert property (p_evt_src) else $error("event without done");
  a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
  a_esc: assert property (p_esc) else $error("escalation field bad");
  a_limit_qos: assert property (p_limit_qos) else $error("limit or qos bad");
  a_rank_row: assert property (p_rank_row) else $error("rank or row slice bad");
  a_hold: assert property (p_hold) else $error("field changed unwritten");
  c_evt: cover property (ch_done_event != 3'h0);
  c_irq: cover property (irq);
  c_stat: cover property (reg_rd && reg_addr == OFF_IRQ_STATUS);
endmodule

bind sccr_regs sccr_regs_monitor u_mon (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_done(seq_done), .irq(irq),
  .ch_done_event(ch_done_event), .ch_max_inflight_requests(ch_max_inflight_requests),
  .ch_priority_raise_periods(ch_priority_raise_periods), .ch_escalation_enable(ch_escalation_enable),
  .ch_service_class(ch_service_class), .ch_start_rank(ch_start_rank), .ch_start_row(ch_start_row)
);

// [tb_scrub_channel_config_regs.sv]
// Purpose: Self-checking bench for the scrub register bank
// Assumes: Read data one cycle after the strobe
// Notes:   Inputs change at rising edges only
module tb_scrub_channel_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import sccr_pkg::*;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, irq;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [2:0] seq_done = 3'h0, done_ev, esc_en, pause, fmt;
  logic [14:0] limit;
  logic [11:0] periods, qos, sbank, ebank;
  logic [5:0] src;
  logic [8:0] srank, erank;
  logic [53:0] srow, erow;
  logic ch4_fmt;
  logic [31:0] ch4_end;
  logic [95:0] saddr, eaddr;
  int failures = 0, comparisons = 0, cycles = 0;
  localparam logic [11:0] OFFS [9] = '{12'h1b8, 12'h1c0, 12'h1c4, 12'h1c8, 12'h1d0,
                                       12'h1d4, 12'h1d8, 12'h1e0, 12'h1e4};
  initial forever #20 clk = ~clk;
  sccr_regs dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .seq_done(seq_done), .irq(irq),
    .ch4_end_address(ch4_end), .ch4_address_format_select(ch4_fmt), .ch_start_address(saddr),
    .ch_end_address(eaddr),
    .ch_max_inflight_requests(limit), .ch_priority_raise_periods(periods),
    .ch_escalation_enable(esc_en), .ch_pause_at_row_boundary(pause), .ch_service_class(qos),
    .ch_address_format_select(fmt), .ch_start_source(src), .ch_start_rank(srank),
    .ch_start_bank(sbank), .ch_start_row(srow), .ch_end_rank(erank), .ch_end_bank(ebank),
    .ch_end_row(erow), .ch_done_event(done_ev)
  );
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask
  // Check lands in the single cycle the data stands
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    fork
      begin
        @(posedge clk);
        #1 chk(reg_rdata, e);
      end
    join_none
  endtask
  task automatic idle;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rd(OFFS[i], OFFS[i][3:0] == 4'h0 ? 32'h1f000000 : 32'h0);
    $display("reset values done");
    wr(OFF_CH5_CTRL, 32'h08052a4b);
    wr(OFF_CH5_START, 32'h01c40123);
    wr(OFF_CH7_START, 32'h01c40123);
    // Reserved bits set; only the limit field may land
    wr(OFF_CH6_CTRL, 32'heaf0c1b4);
    idle;
    chk(limit[4:0], 5'd8);
    chk(limit[9:5], 5'd10);
    chk(periods[3:0], 4'd5);
    chk(esc_en[1:0], 2'b01);
    chk(pause[1:0], 2'b01);
    chk(qos[3:0], 4'd5);
    chk(fmt[1:0], 2'b01);
    chk(src[3:0], 4'h3);
    chk({srank[2:0], sbank[3:0], srow[17:0]}, {3'd7, 4'd1, 18'h123});
    chk(saddr[31:0], 32'h01c40123);
    chk(saddr[95:64], 32'h01c40123);
    rd(OFF_CH6_CTRL, 32'h0a000000);
    rd(OFF_CH5_START, 32'h01c40123);
    // Strobe must drop before the event stimulus
    idle;
    $display("field decode done");
    @(posedge clk);
    seq_done <= 3'b011;
    @(posedge clk);
    seq_done <= 3'b000;
    #1 chk({irq, done_ev}, 4'b0001);
    rd(OFF_IRQ_STATUS, 32'h1);
    wr(OFF_IRQ_MASK, 32'h1);
    idle;
    chk(irq, 1'b1);
    wr(OFF_IRQ_STATUS, 32'h1);
    idle;
    chk(irq, 1'b0);
    $display("event test done");
    for (int i = 0; i < 9; i++) begin
      wr(OFFS[i], 32'hffffffff);
      rd(OFFS[i], OFFS[i][3:0] == 4'h0 ? 32'h1f0f3e4b : 32'hffffffff);
    end
    wr(12'h1e8, 32'hffffffff);
    rd(12'h1e8, 32'h0);
    idle;
    chk(ch4_end, 32'hffffffff);
    chk(eaddr[63:32], 32'hffffffff);
    chk(eaddr[95:64], 32'h0);
    chk(saddr[95:64], 32'hffffffff);
    chk({erank[2:0], ebank[3:0], erow[17:0]}, 25'h1ffffff);
    chk({ch4_fmt, fmt}, 4'b0111);
    $display("write readback done");
    // Reset in mid-run must restore every register
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_CH5_CTRL, 32'h1f000000);
    rd(OFF_CH7_START, 32'h0);
    idle;
    chk({limit, periods[3:0]}, {15'h7fff, 4'h0});
    chk(ch4_end | eaddr[31:0] | saddr[31:0], 32'h0);
    chk({irq, done_ev, esc_en}, 7'h0);
    repeat (2) @(posedge clk);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule
